// ### verilog/ptr_target.sv
// Target read path: 32-bit PCI bus, 64-bit local back-end.
`timescale 1ns/1ps
// Function
// R01: Master drives frame, address, read command.
// R02: Master floats AD, drives byte enables, IRDY.
// R03: Core decodes and presents local address.
// R04: Matching base-hit bit driven to back-end.
// R05: Slow option: DEVSEL one clock after hit.
// R06: Back-end ready one clock before data.
// R07: Strobe low or high by alignment after ready.
// R08: Back-end puts first DWORD on matching half.
// R09: TRDY with IRDY drives first DWORD.
// R10: QWORD start: low off, high on IRDY.
// R11: Back-end holds QWORD until high strobe.
// R12: DWORD start: two readies then TRDY, upper.
// R13: DWORD start: high off, low on IRDY+ready.
// R14: Second phase keeps TRDY, drives DWORD two.
// R15: Master releases frame, drops IRDY after ack.
// R16: Core stops AD, drops DEVSEL and TRDY.
// R17: Idle: release, clear hit, drop strobes.
// R18: Aligned start takes lower half first.
// R19: Strobes name the DWORD being transferred.
// R20: Strobes active low, rising edge only.
module ptr_target
  import ptr_pkg::*;
#(
  parameter logic [AD_W-1:0] BAR_BASE = BAR0_BASE,
  parameter logic [AD_W-1:0] BAR_MSK  = BAR_MASK,
  parameter bit              SLOW_SEL = 1'b1
)(
  input  wire logic                   core_clk,
  input  wire logic                   rst_n,
  ptr_pci_if.target                   bus,
  input  wire logic                   select_speed_option,
  output      logic [AD_W-1:0]        local_target_addr_o,
  output      logic [BAR_N-1:0]       bar_hit_o,
  input  wire logic                   backend_ready_n,
  input  wire logic [LD_W-1:0]        local_data_i,
  output      logic                   low_dword_strobe_n,
  output      logic                   high_dword_strobe_n
);
  import ptr_pkg::*;
  ptr_state_t       st_q;
  logic [AD_W-1:0]  addr_q;
  logic [3:0]       cmd_q;
  logic             dw_start_q;
  logic             rdy_prev_q;
  logic             first_q;
  logic             irdy_prev_q;
  logic             ack;

  // Base match: unused windows are never hit in this build.
  function automatic logic bar_match(input logic [AD_W-1:0] a);
    bar_match = ((a & BAR_MSK) == (BAR_BASE & BAR_MSK));
  endfunction : bar_match

  assign ack = !bus.trdy_n && !bus.irdy_n;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irdy_prev_q <= 1'b0;
      rdy_prev_q  <= 1'b0;
    end else begin
      irdy_prev_q <= !bus.irdy_n;
      rdy_prev_q  <= !backend_ready_n; // R06
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin // R20
    if (!rst_n) begin
      st_q                <= PTR_IDLE;
      addr_q              <= '0;
      cmd_q               <= '0;
      dw_start_q          <= 1'b0;
      first_q             <= 1'b1;
      local_target_addr_o <= '0;
      bar_hit_o           <= '0;
      bus.devsel_n        <= 1'b1;
      bus.trdy_n          <= 1'b1;
      bus.tgt_oe          <= 1'b0;
      bus.ad_t_o          <= '0;
      bus.ad_t_oe         <= 1'b0;
      low_dword_strobe_n  <= 1'b1;
      high_dword_strobe_n <= 1'b1;
    end else begin
      case (st_q)
        PTR_IDLE: begin
          if (!bus.frame_n) begin
            addr_q     <= bus.ad;
            cmd_q      <= bus.cbe_n;
            dw_start_q <= bus.ad[QW_BIT]; // R18
            st_q       <= PTR_DEC;
          end
        end
        PTR_DEC: begin
          local_target_addr_o <= addr_q; // R03
          if (bar_match(addr_q) && cmd_q == CMD_MRD) begin
            bar_hit_o[0] <= 1'b1; // R04
            st_q         <= PTR_HIT;
          end else begin
            st_q <= PTR_IDLE;
          end
        end
        PTR_HIT: begin
          // Fast and slow options both claim at once; neither waits this clock.
          bus.devsel_n <= 1'b0; // R05
          bus.tgt_oe   <= 1'b1;
          first_q      <= 1'b1;
          st_q         <= (SLOW_SEL || select_speed_option) ?
                          PTR_SEL : PTR_SEL;
        end
        PTR_SEL: begin
          // Ready is seen at this edge, so the strobe shows one clock later.
          if (!backend_ready_n && low_dword_strobe_n && high_dword_strobe_n)
          begin
            low_dword_strobe_n  <= dw_start_q; // R07
            high_dword_strobe_n <= !dw_start_q; // R07
          end
          if (!dw_start_q && !low_dword_strobe_n) begin
            // Aligned start: lower half goes out first.
            bus.trdy_n          <= 1'b0; // R09
            bus.ad_t_o          <= local_data_i[AD_W-1:0]; // R18
            bus.ad_t_oe         <= 1'b1;
            low_dword_strobe_n  <= 1'b1; // R10
            high_dword_strobe_n <= !irdy_prev_q; // R10
            st_q                <= PTR_DATA;
          end
          if (dw_start_q && !high_dword_strobe_n && rdy_prev_q
              && !backend_ready_n) begin
            // Two readies in a row: upper half first, lower half strobed next.
            bus.trdy_n          <= 1'b0; // R12
            bus.ad_t_o          <= local_data_i[LD_W-1:AD_W]; // R12
            bus.ad_t_oe         <= 1'b1;
            high_dword_strobe_n <= 1'b1; // R13
            low_dword_strobe_n  <= !(irdy_prev_q && rdy_prev_q); // R13
            st_q                <= PTR_DATA;
          end
        end
        PTR_DATA: begin
          if (ack && first_q) begin
            first_q <= 1'b0;
            // The strobe active this clock names the half loaded onto AD.
            bus.ad_t_o <= dw_start_q ? local_data_i[AD_W-1:0]
                                     : local_data_i[LD_W-1:AD_W]; // R19
            bus.trdy_n <= 1'b0; // R14
            low_dword_strobe_n  <= 1'b1;
            high_dword_strobe_n <= 1'b1;
          end else if (ack) begin
            // Second acknowledge: the next clock is the turnaround clock.
            bus.ad_t_oe  <= 1'b0; // R16
            bus.devsel_n <= 1'b1; // R16
            bus.trdy_n   <= 1'b1; // R16
            st_q         <= PTR_TURN;
          end
        end
        PTR_TURN, PTR_END: begin
          bus.tgt_oe          <= 1'b0; // R17
          bus.devsel_n        <= 1'b1; // R17
          bus.trdy_n          <= 1'b1; // R17
          bar_hit_o           <= '0; // R17
          low_dword_strobe_n  <= 1'b1; // R17
          high_dword_strobe_n <= 1'b1; // R17
          st_q                <= PTR_IDLE;
        end
        default: st_q <= PTR_IDLE;
      endcase
    end
  end
endmodule : ptr_target

// ### verilog/ptr_pkg.sv
// Shared constants and types for the PCI target read bridge.
package ptr_pkg;
  localparam int unsigned AD_W      = 32;
  localparam int unsigned LD_W      = 64;
  localparam int unsigned CBE_W     = 4;
  localparam int unsigned BAR_N     = 6;
  localparam logic [3:0]  CMD_MRD   = 4'h6;
  localparam logic [3:0]  CMD_MWR   = 4'h7;
  localparam int unsigned QW_BIT    = 2;
  localparam logic [31:0] BAR0_BASE = 32'h1000_0000;
  localparam logic [31:0] BAR_MASK  = 32'hFFFF_F000;
  localparam int unsigned MASTER_BURST = 2;
  localparam logic [1:0]  CNT_ZERO  = 2'h0;
  localparam logic [1:0]  CNT_ONE   = 2'h1;
  typedef enum logic [2:0] {
    PTR_IDLE = 3'b000,
    PTR_DEC  = 3'b001,
    PTR_HIT  = 3'b010,
    PTR_SEL  = 3'b011,
    PTR_DATA = 3'b100,
    PTR_TURN = 3'b101,
    PTR_END  = 3'b110
  } ptr_state_t;
endpackage : ptr_pkg

// ### verilog/ptr_pci_if.sv
// PCI bus signals between an external master and the target core.
`timescale 1ns/1ps
interface ptr_pci_if;
  import ptr_pkg::*;
  logic [AD_W-1:0]  ad_m_o;
  logic             ad_m_oe;
  logic [AD_W-1:0]  ad_t_o;
  logic             ad_t_oe;
  logic [CBE_W-1:0] cbe_n;
  logic             cbe_oe;
  logic             frame_n;
  logic             irdy_n;
  logic             trdy_n;
  logic             devsel_n;
  logic             tgt_oe;
  wire  [AD_W-1:0]  ad = ad_t_oe ? ad_t_o : (ad_m_oe ? ad_m_o : '0);
  modport master (output ad_m_o, ad_m_oe, cbe_n, cbe_oe, frame_n, irdy_n,
                  input ad, trdy_n, devsel_n, tgt_oe);
  modport target (output ad_t_o, ad_t_oe, trdy_n, devsel_n, tgt_oe,
                  input ad, cbe_n, frame_n, irdy_n);
endinterface : ptr_pci_if

// ### verilog/ptr_master.sv
// PCI master end: issues one memory read of two DWORDs.
`timescale 1ns/1ps
module ptr_master
  import ptr_pkg::*;
(
  input  wire logic                   core_clk,
  input  wire logic                   rst_n,
  ptr_pci_if.master                   bus,
  input  wire logic                   start_i,
  input  wire logic [AD_W-1:0]        addr_i,
  output      logic                   busy_o,
  output      logic                   rd_valid_o,
  output      logic [AD_W-1:0]        rd_data_o
);
  import ptr_pkg::*;
  typedef enum logic [1:0] {
    PM_IDLE = 2'b00, PM_ADDR = 2'b01, PM_DATA = 2'b10, PM_TURN = 2'b11
  } ptr_mst_t;
  ptr_mst_t         st_q;
  logic [1:0]       left_q;
  logic             ack;
  assign ack = !bus.trdy_n && !bus.irdy_n;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q         <= PM_IDLE;
      left_q       <= CNT_ZERO;
      bus.frame_n  <= 1'b1;
      bus.irdy_n   <= 1'b1;
      bus.ad_m_oe  <= 1'b0;
      bus.ad_m_o   <= '0;
      bus.cbe_n    <= '1;
      bus.cbe_oe   <= 1'b0;
      busy_o       <= 1'b0;
      rd_valid_o   <= 1'b0;
      rd_data_o    <= '0;
    end else begin
      rd_valid_o <= 1'b0;
      case (st_q)
        PM_IDLE: begin
          if (start_i) begin
            // Address clock: frame, address and read command.
            bus.frame_n <= 1'b0; // R01
            bus.ad_m_o  <= addr_i; // R01
            bus.ad_m_oe <= 1'b1;
            bus.cbe_n   <= CMD_MRD; // R01
            bus.cbe_oe  <= 1'b1;
            left_q      <= 2'(MASTER_BURST);
            busy_o      <= 1'b1;
            st_q        <= PM_ADDR;
          end
        end
        PM_ADDR: begin
          bus.ad_m_oe <= 1'b0; // R02
          bus.cbe_n   <= '0; // R02
          bus.irdy_n  <= 1'b0; // R02
          st_q        <= PM_DATA;
        end
        PM_DATA: begin
          if (ack) begin
            rd_valid_o <= 1'b1;
            rd_data_o  <= bus.ad;
            left_q     <= left_q - CNT_ONE;
            if (left_q == 2'h2) begin
              // Frame drops with the last data phase pending.
              bus.frame_n <= 1'b1;
            end else begin
              bus.irdy_n <= 1'b1; // R15
              bus.cbe_oe <= 1'b0; // R15
              st_q       <= PM_TURN;
            end
          end
        end
        PM_TURN: begin
          busy_o <= 1'b0;
          st_q   <= PM_IDLE;
        end
        default: st_q <= PM_IDLE;
      endcase
    end
  end
endmodule : ptr_master

// ### verification/ptr_checker.sv
// Assertions on the PCI wires between the master and target ends.
`timescale 1ns/1ps
module ptr_checker
  import ptr_pkg::*;
(
  input wire logic             core_clk,
  input wire logic             rst_n,
  input wire logic             ad_m_oe,
  input wire logic             ad_t_oe,
  input wire logic [CBE_W-1:0] cbe_n,
  input wire logic             cbe_oe,
  input wire logic             frame_n,
  input wire logic             irdy_n,
  input wire logic             trdy_n,
  input wire logic             devsel_n,
  input wire logic             tgt_oe
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  property p_cmd;
    $fell(frame_n) |-> ad_m_oe && cbe_oe && cbe_n == CMD_MRD;
  endproperty
  a_cmd: assert property (p_cmd) else $error("no read command");
  property p_irdy;
    $fell(frame_n) |=> !ad_m_oe && !irdy_n;
  endproperty
  a_irdy: assert property (p_irdy) else $error("ad not floated");
  property p_sel;
    $fell(devsel_n) |-> !$past(frame_n, 3) && $past(frame_n, 4);
  endproperty
  a_sel: assert property (p_sel) else $error("select timing");
  property p_data;
    !trdy_n && !irdy_n |-> ad_t_oe && !devsel_n;
  endproperty
  a_data: assert property (p_data) else $error("data not driven");
  property p_two;
    $fell(trdy_n) |=> !trdy_n ##1 trdy_n;
  endproperty
  a_two: assert property (p_two) else $error("not two phases");
  property p_turn;
    $rose(trdy_n) |-> $rose(devsel_n) && !ad_t_oe;
  endproperty
  a_turn: assert property (p_turn) else $error("turnaround");
  property p_idle;
    $rose(trdy_n) |=> !tgt_oe;
  endproperty
  a_idle: assert property (p_idle) else $error("not released");
  property p_mrel;
    $rose(trdy_n) |-> irdy_n && frame_n && !cbe_oe;
  endproperty
  a_mrel: assert property (p_mrel) else $error("master holds");
endmodule : ptr_checker

// ### verification/tb_pci32_target_read_local64.sv
// Bench joining the master and target ends over the PCI interface.
`timescale 1ns/1ps
module tb_pci32_target_read_local64;
  import ptr_pkg::*;
  typedef struct packed {
    logic [31:0] a;
    logic [1:0]  lag;
    logic [31:0] d1;
    logic [31:0] d2;
  } ptr_row_t;
  logic             core_clk = 1'b0;
  logic             rst_n = 1'b0;
  logic             start_i = 1'b0;
  logic [AD_W-1:0]  addr_i = '0;
  logic             sel_opt = 1'b1;
  logic             backend_ready_n = 1'b1;
  logic [LD_W-1:0]  local_data_i;
  logic [1:0]       lag_q = '0;
  logic [1:0]       wait_q = '0;
  logic [31:0]      idx_q = '0;
  logic             busy_o;
  logic             rd_valid_o;
  logic [AD_W-1:0]  rd_data_o;
  logic [AD_W-1:0]  laddr;
  logic [BAR_N-1:0] bar_hit_o;
  logic             lo_n;
  logic             hi_n;
  int               error_cnt = 0;
  int               checks_done = 0;
  int               n;
  ptr_row_t rows [4] = '{
    '{32'h1000_0000, 2'h0, 32'h1111_0000, 32'h2222_0000},
    '{32'h1000_0004, 2'h0, 32'h2222_0000, 32'h1111_0001},
    '{32'h1000_0FF8, 2'h2, 32'h1111_0000, 32'h2222_0000},
    '{32'h1000_0FFC, 2'h3, 32'h2222_0000, 32'h1111_0001}};
  always #50 core_clk = ~core_clk;
  ptr_pci_if ptr_pci_if_i ();
  ptr_master ptr_master_i (.core_clk(core_clk), .rst_n(rst_n),
    .bus(ptr_pci_if_i), .start_i(start_i), .addr_i(addr_i),
    .busy_o(busy_o), .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o));
  ptr_target ptr_target_i (.core_clk(core_clk), .rst_n(rst_n),
    .bus(ptr_pci_if_i), .select_speed_option(sel_opt),
    .local_target_addr_o(laddr), .bar_hit_o(bar_hit_o),
    .backend_ready_n(backend_ready_n), .local_data_i(local_data_i),
    .low_dword_strobe_n(lo_n), .high_dword_strobe_n(hi_n));
  ptr_checker ptr_checker_i (.core_clk(core_clk), .rst_n(rst_n),
    .ad_m_oe(ptr_pci_if_i.ad_m_oe), .ad_t_oe(ptr_pci_if_i.ad_t_oe),
    .cbe_n(ptr_pci_if_i.cbe_n), .cbe_oe(ptr_pci_if_i.cbe_oe),
    .frame_n(ptr_pci_if_i.frame_n), .irdy_n(ptr_pci_if_i.irdy_n),
    .trdy_n(ptr_pci_if_i.trdy_n), .devsel_n(ptr_pci_if_i.devsel_n),
    .tgt_oe(ptr_pci_if_i.tgt_oe));
  // Unselected, the back-end shows inverted data so early sampling fails.
  assign local_data_i = {32'h2222_0000 + idx_q, 32'h1111_0000 + idx_q}
                        ^ {LD_W{~bar_hit_o[0]}};
  always @(posedge core_clk) begin
    if (bar_hit_o == '0) begin
      idx_q <= '0;
      wait_q <= '0;
      backend_ready_n <= 1'b1;
    end else begin
      if (wait_q < lag_q) wait_q <= wait_q + 2'h1;
      else backend_ready_n <= 1'b0;
      if (!hi_n) idx_q <= idx_q + 32'h1;
    end
  end
  task automatic chk(input string nm, input logic [31:0] got, exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s exp %h got %h", nm, exp, got);
    end
  endtask : chk
  task automatic go(input logic [31:0] a);
    @(posedge core_clk);
    start_i <= 1'b1;
    addr_i <= a;
    @(posedge core_clk);
    start_i <= 1'b0;
  endtask : go
  task automatic run(input ptr_row_t r);
    lag_q <= r.lag;
    go(r.a);
    for (n = 0; n < 40 && lo_n && hi_n; n++) @(negedge core_clk);
    chk("hit", 32'(bar_hit_o), 32'h1);
    chk("laddr", laddr, r.a);
    chk("strobe1", 32'({lo_n, hi_n}), r.a[2] ? 32'h2 : 32'h1);
    @(negedge core_clk);
    chk("strobe2", 32'({lo_n, hi_n}), r.a[2] ? 32'h1 : 32'h2);
    for (int i = 0; i < 2; i++) begin
      for (n = 0; n < 40 && !rd_valid_o; n++) @(negedge core_clk);
      chk("valid", 32'(rd_valid_o), 32'h1);
      chk("data", rd_data_o, i ? r.d2 : r.d1);
      @(negedge core_clk);
    end
    for (n = 0; n < 40 && (busy_o || bar_hit_o != '0); n++)
      @(negedge core_clk);
    chk("end", 32'({bar_hit_o, lo_n, hi_n}), 32'h3);
  endtask : run
  task automatic complete_run();
    $display("errors %0d checks %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : complete_run
  initial begin
    #400000;
    error_cnt++;
    complete_run();
  end
  initial begin
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    foreach (rows[k]) run(rows[k]);
    // A miss leaves the master without an answer, so reset recovers it.
    go(32'h2000_0000);
    repeat (12) begin
      @(negedge core_clk);
      chk("miss", 32'({ptr_pci_if_i.devsel_n, bar_hit_o}), 32'h40);
    end
    @(posedge core_clk);
    rst_n <= 1'b0;
    @(negedge core_clk);
    chk("reset", 32'({busy_o, lo_n, hi_n, bar_hit_o}), 32'hC0);
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    run(rows[1]);
    complete_run();
  end
endmodule : tb_pci32_target_read_local64
